/* File: hw/ccc_map.svh */
`ifndef CCC_MAP_SVH
`define CCC_MAP_SVH

// ==========================================
// Geometry
`define CCC_NCH 4
`define CCC_NCOEF 65
`define CCC_RW_BIT 7
`define CCC_FRAC_BITS 15

// ==========================================
// Command identifiers
`define CCC_ID_LINE_MATCH 7'h31
`define CCC_ID_TIMEOUT 7'h32
`define CCC_ID_RX_GAIN 7'h40
`define CCC_ID_TX_GAIN 7'h41
`define CCC_ID_FILT_R 7'h42
`define CCC_ID_FILT_X 7'h43
`define CCC_ID_FILT_B 7'h44
`define CCC_ID_FILT_Z 7'h45

// ==========================================
// Payload lengths in words, and storage bases
`define CCC_WORDS_ONE 5'd1
`define CCC_WORDS_R 5'd17
`define CCC_WORDS_X 5'd17
`define CCC_WORDS_B 5'd26
`define CCC_WORDS_Z 5'd5
`define CCC_BASE_R 7'd0
`define CCC_BASE_X 7'd17
`define CCC_BASE_B 7'd34
`define CCC_BASE_Z 7'd60

// ==========================================
// Field positions and reset values
`define CCC_METER_BIT 8
`define CCC_TOUT_EN_BIT 0
`define CCC_LINE_MATCH_RST 16'haa00
`define CCC_TIMEOUT_RST 16'hffff
`define CCC_GAIN_RST 16'h0000
`define CCC_COEF_RST 16'h0000

// ==========================================
// Timeout scale, in picoseconds
`define CCC_TOUT_STEP_PS 32'd62500
`define CCC_TOUT_OFFS_PS 32'd31240

`endif

/* File: hw/ccc_pkg.sv */
`default_nettype none
package ccc_pkg;
    typedef logic [15:0] ccc_word_t;
    typedef logic [6:0] ccc_id_t;
    typedef enum logic [1:0] {
        ccc_st_idle,
        ccc_st_cmd,
        ccc_st_data,
        ccc_st_skip
    } ccc_state_e;
endpackage
`default_nettype wire

/* File: hw/ccc_gain_if.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Gain word and sample path between core and gain stage
interface ccc_gain_if;
    logic [15:0] gain;
    logic [15:0] sample_in;
    logic [15:0] sample_out;
    modport ctrl (output gain, output sample_in, input sample_out);
    modport stage (input gain, input sample_in, output sample_out);
endinterface
`default_nettype wire

/* File: hw/ccc_gain_stage.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ccc_map.svh"
module ccc_gain_stage
    import ccc_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    ccc_gain_if.stage gio
);
    logic signed [31:0] prod;

    // Q15 product; gain of 7fff keeps the result inside 16 bits
    assign prod = $signed(gio.sample_in) * $signed(gio.gain);

    // Zero gain forces silence rather than a tiny residue
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            gio.sample_out <= 16'h0000;
        else if (gio.gain == 16'h0000)
            gio.sample_out <= 16'h0000;
        else
            gio.sample_out <= prod[`CCC_FRAC_BITS +: 16];
    end

    // ==========================================
    // Checks
    property p_gain_scale;
        @(posedge core_clk) disable iff (!nrst)
        (gio.gain != 16'h0000) |=> (gio.sample_out == $past(prod[30:15]));
    endproperty
    a_gain_scale: assert property (p_gain_scale) else $error("gain product wrong");

    property p_gain_zero;
        @(posedge core_clk) disable iff (!nrst)
        (gio.gain == 16'h0000) |=> (gio.sample_out == 16'h0000);
    endproperty
    a_gain_zero: assert property (p_gain_zero) else $error("zero gain not silent");
endmodule
`default_nettype wire

/* File: hw/ccc_cmd_core.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ccc_map.svh"
module ccc_cmd_core
    import ccc_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic cs_n,
    input wire logic cclk,
    input wire logic ci,
    output logic co_out,
    output logic co_oe,
    input wire logic [3:0] channel_command_mask,
    input wire logic [63:0] rx_sample,
    input wire logic [63:0] tx_sample,
    output logic [63:0] receive_analog_output,
    output logic [63:0] pcm_transmit_output,
    output logic [3:0] line_match_en,
    output logic [3:0] line_match_900,
    output logic metering_pulse_flag,
    output logic timeout_enable_bit,
    output logic [31:0] timeout_len_ps,
    output logic [3:0] rx_muted,
    output logic [3:0] tx_nulled
);
    // ==========================================
    // Decode helpers
    function automatic logic [4:0] cmd_words(input ccc_id_t id);
        case (id)
            `CCC_ID_LINE_MATCH, `CCC_ID_TIMEOUT: cmd_words = `CCC_WORDS_ONE;
            `CCC_ID_RX_GAIN, `CCC_ID_TX_GAIN: cmd_words = `CCC_WORDS_ONE;
            `CCC_ID_FILT_R: cmd_words = `CCC_WORDS_R;
            `CCC_ID_FILT_X: cmd_words = `CCC_WORDS_X;
            `CCC_ID_FILT_B: cmd_words = `CCC_WORDS_B;
            `CCC_ID_FILT_Z: cmd_words = `CCC_WORDS_Z;
            default: cmd_words = 5'h00;
        endcase
    endfunction

    function automatic logic [6:0] coef_base(input ccc_id_t id);
        case (id)
            `CCC_ID_FILT_X: coef_base = `CCC_BASE_X;
            `CCC_ID_FILT_B: coef_base = `CCC_BASE_B;
            `CCC_ID_FILT_Z: coef_base = `CCC_BASE_Z;
            default: coef_base = `CCC_BASE_R;
        endcase
    endfunction

    function automatic logic is_coef(input ccc_id_t id);
        is_coef = (id >= `CCC_ID_FILT_R) && (id <= `CCC_ID_FILT_Z);
    endfunction

    // Only the two single-pattern codes enable matching
    function automatic logic lm_enabled(input logic [1:0] p);
        lm_enabled = (p == 2'b10) || (p == 2'b01);
    endfunction

    // ==========================================
    // Pin synchronisers and filters
    logic [2:0] cs_sy_reg;
    logic [2:0] clk_sy_reg;
    logic [2:0] ci_sy_reg;
    logic cs_f_reg;
    logic clk_f_reg;
    logic ci_f_reg;
    logic clk_d_reg;

    // A level counts only once stages two and three agree
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cs_sy_reg <= 3'h7;
            clk_sy_reg <= 3'h7;
            ci_sy_reg <= 3'h0;
            cs_f_reg <= 1'b1;
            clk_f_reg <= 1'b1;
            ci_f_reg <= 1'b0;
            clk_d_reg <= 1'b1;
        end
        else
        begin
            cs_sy_reg <= {cs_sy_reg[1:0], cs_n};
            clk_sy_reg <= {clk_sy_reg[1:0], cclk};
            ci_sy_reg <= {ci_sy_reg[1:0], ci};
            if (cs_sy_reg[1] == cs_sy_reg[2])
                cs_f_reg <= cs_sy_reg[2];
            if (clk_sy_reg[1] == clk_sy_reg[2])
                clk_f_reg <= clk_sy_reg[2];
            if (ci_sy_reg[1] == ci_sy_reg[2])
                ci_f_reg <= ci_sy_reg[2];
            clk_d_reg <= clk_f_reg;
        end
    end

    // ==========================================
    // Frame engine
    ccc_state_e state_reg;
    logic [2:0] bit_cnt_reg;
    logic hi_reg;
    logic [7:0] sh_reg;
    logic [7:0] lo_reg;
    ccc_id_t id_reg;
    logic rd_reg;
    logic [4:0] idx_reg;
    logic clk_fall;
    logic byte_done;
    logic [7:0] sh_next;
    logic wr_fire;
    ccc_word_t wr_word;
    logic [6:0] wr_addr;

    // Data is taken on the falling shift-clock edge
    assign clk_fall = clk_d_reg & ~clk_f_reg;
    assign sh_next = {sh_reg[6:0], ci_f_reg};
    assign byte_done = clk_fall && (bit_cnt_reg == 3'h7) && !cs_f_reg;
    assign wr_fire = (state_reg == ccc_st_data) && byte_done && hi_reg && !rd_reg;
    assign wr_word = {sh_next, lo_reg};
    assign wr_addr = coef_base(id_reg) + {2'h0, idx_reg};

    // Low byte first, each byte most significant bit first
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_reg <= ccc_st_idle;
            bit_cnt_reg <= 3'h0;
            hi_reg <= 1'b0;
            sh_reg <= 8'h00;
            lo_reg <= 8'h00;
            id_reg <= 7'h00;
            rd_reg <= 1'b0;
            idx_reg <= 5'h00;
        end
        else if (cs_f_reg)
        begin
            state_reg <= ccc_st_idle;
            bit_cnt_reg <= 3'h0;
            hi_reg <= 1'b0;
        end
        else
        begin
            if (clk_fall)
            begin
                sh_reg <= sh_next;
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
            end
            case (state_reg)
                ccc_st_idle:
                begin
                    state_reg <= ccc_st_cmd;
                    bit_cnt_reg <= 3'h0;
                end
                ccc_st_cmd:
                    if (byte_done)
                    begin
                        id_reg <= sh_next[6:0];
                        rd_reg <= sh_next[`CCC_RW_BIT];
                        idx_reg <= 5'h00;
                        hi_reg <= 1'b0;
                        // Unknown commands are swallowed until chip select rises
                        if (cmd_words(sh_next[6:0]) != 5'h00)
                            state_reg <= ccc_st_data;
                        else
                            state_reg <= ccc_st_skip;
                    end
                ccc_st_data:
                    if (byte_done)
                    begin
                        if (!hi_reg)
                        begin
                            lo_reg <= sh_next;
                            hi_reg <= 1'b1;
                        end
                        else
                        begin
                            hi_reg <= 1'b0;
                            idx_reg <= idx_reg + 5'h01;
                            if (idx_reg == cmd_words(id_reg) - 5'h01)
                                state_reg <= ccc_st_skip;
                        end
                    end
                ccc_st_skip:
                    state_reg <= ccc_st_skip;
                default:
                    state_reg <= ccc_st_idle;
            endcase
        end
    end

    // ==========================================
    // Storage
    ccc_word_t line_match_reg;
    ccc_word_t timeout_reg;
    ccc_word_t rx_gain_reg [`CCC_NCH];
    ccc_word_t tx_gain_reg [`CCC_NCH];
    ccc_word_t coef_mem [`CCC_NCH][`CCC_NCOEF];

    // Device-wide settings, the channel mask does not apply
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            line_match_reg <= `CCC_LINE_MATCH_RST;
            timeout_reg <= `CCC_TIMEOUT_RST;
        end
        else if (wr_fire)
        begin
            if (id_reg == `CCC_ID_LINE_MATCH)
                line_match_reg <= wr_word;
            if (id_reg == `CCC_ID_TIMEOUT)
                timeout_reg <= wr_word;
        end
    end

    // Gain words fan out to every masked channel
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int c = 0; c < `CCC_NCH; c++)
            begin
                rx_gain_reg[c] <= `CCC_GAIN_RST;
                tx_gain_reg[c] <= `CCC_GAIN_RST;
            end
        end
        else
        begin
            for (int c = 0; c < `CCC_NCH; c++)
            begin
                if (wr_fire && channel_command_mask[c] && id_reg == `CCC_ID_RX_GAIN)
                    rx_gain_reg[c] <= wr_word;
                if (wr_fire && channel_command_mask[c] && id_reg == `CCC_ID_TX_GAIN)
                    tx_gain_reg[c] <= wr_word;
            end
        end
    end

    // Filter sets share one flat table per channel
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int c = 0; c < `CCC_NCH; c++)
                for (int k = 0; k < `CCC_NCOEF; k++)
                    coef_mem[c][k] <= `CCC_COEF_RST;
        end
        else
        begin
            for (int c = 0; c < `CCC_NCH; c++)
                if (wr_fire && channel_command_mask[c] && is_coef(id_reg))
                    coef_mem[c][wr_addr] <= wr_word;
        end
    end

    // ==========================================
    // Read-back
    ccc_id_t rd_id;
    logic [4:0] rd_idx;
    logic [1:0] rd_ch;
    logic [6:0] rd_addr;
    ccc_word_t rd_val;
    ccc_word_t tx_word_reg;

    // Lowest masked channel answers reads of per-channel data
    always_comb
    begin
        rd_id = (state_reg == ccc_st_cmd) ? sh_next[6:0] : id_reg;
        rd_idx = (state_reg == ccc_st_cmd) ? 5'h00 : idx_reg + 5'h01;
        rd_ch = 2'h0;
        for (int c = `CCC_NCH - 1; c >= 0; c--)
            if (channel_command_mask[c])
                rd_ch = 2'(c);
        rd_addr = coef_base(rd_id) + {2'h0, rd_idx};
        rd_val = 16'h0000;
        case (rd_id)
            `CCC_ID_LINE_MATCH: rd_val = line_match_reg;
            `CCC_ID_TIMEOUT: rd_val = timeout_reg;
            `CCC_ID_RX_GAIN: rd_val = rx_gain_reg[rd_ch];
            `CCC_ID_TX_GAIN: rd_val = tx_gain_reg[rd_ch];
            default:
                if (is_coef(rd_id) && rd_addr < 7'(`CCC_NCOEF))
                    rd_val = coef_mem[rd_ch][rd_addr];
        endcase
    end

    // Next word is fetched at each word boundary
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            tx_word_reg <= 16'h0000;
        else if (byte_done && (state_reg == ccc_st_cmd || (state_reg == ccc_st_data && hi_reg)))
            tx_word_reg <= rd_val;
    end

    // Reply bit follows the same low-byte-first order
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            co_oe <= 1'b0;
            co_out <= 1'b0;
        end
        else
        begin
            co_oe <= !cs_f_reg && state_reg == ccc_st_data && rd_reg;
            co_out <= (!cs_f_reg && state_reg == ccc_st_data && rd_reg)
                      ? tx_word_reg[{hi_reg, ~bit_cnt_reg}] : 1'b0;
        end
    end

    // ==========================================
    // Decoded controls
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            line_match_en <= 4'h0;
            line_match_900 <= 4'h0;
            rx_muted <= 4'h0;
            tx_nulled <= 4'h0;
            metering_pulse_flag <= 1'b0;
            timeout_enable_bit <= 1'b0;
            timeout_len_ps <= 32'h0000_0000;
        end
        else
        begin
            for (int c = 0; c < `CCC_NCH; c++)
            begin
                line_match_en[c] <= lm_enabled(line_match_reg[2 * c +: 2]);
                line_match_900[c] <= line_match_reg[2 * c +: 2] == 2'b01;
                rx_muted[c] <= rx_gain_reg[c] == 16'h0000;
                tx_nulled[c] <= tx_gain_reg[c] == 16'h0000;
            end
            metering_pulse_flag <= line_match_reg[`CCC_METER_BIT];
            timeout_enable_bit <= timeout_reg[`CCC_TOUT_EN_BIT];
            timeout_len_ps <= {17'h0, timeout_reg[15:1]} * `CCC_TOUT_STEP_PS
                              + `CCC_TOUT_OFFS_PS;
        end
    end

    // ==========================================
    // Gain stages, one per direction and channel
    for (genvar g = 0; g < `CCC_NCH; g++)
    begin : g_ch
        ccc_gain_if rx_if ();
        ccc_gain_if tx_if ();
        assign rx_if.gain = rx_gain_reg[g];
        assign rx_if.sample_in = rx_sample[16 * g +: 16];
        assign tx_if.gain = tx_gain_reg[g];
        assign tx_if.sample_in = tx_sample[16 * g +: 16];
        ccc_gain_stage u_rx (.core_clk(core_clk), .nrst(nrst), .gio(rx_if.stage));
        ccc_gain_stage u_tx (.core_clk(core_clk), .nrst(nrst), .gio(tx_if.stage));
        assign receive_analog_output[16 * g +: 16] = rx_if.sample_out;
        assign pcm_transmit_output[16 * g +: 16] = tx_if.sample_out;
    end

    // ==========================================
    // Checks
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);

    logic tout_written_reg;
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            tout_written_reg <= 1'b0;
        else if (wr_fire && id_reg == `CCC_ID_TIMEOUT)
            tout_written_reg <= 1'b1;
    end

    sequence s_tx_silent;
        (tx_gain_reg[0] == 16'h0000) [*2];
    endsequence
    sequence s_tout_read;
        state_reg == ccc_st_cmd && byte_done && sh_next == {1'b1, `CCC_ID_TIMEOUT};
    endsequence

    property p_lm_decode;
        1'b1 |=> line_match_en[1] == lm_enabled($past(line_match_reg[3:2]));
    endproperty
    a_lm_decode: assert property (p_lm_decode) else $error("line match decode");
    property p_meter;
        1'b1 |=> metering_pulse_flag == $past(line_match_reg[`CCC_METER_BIT]);
    endproperty
    a_meter: assert property (p_meter) else $error("metering flag");
    property p_tout_en;
        $changed(timeout_reg) |=> timeout_enable_bit == $past(timeout_reg[0]);
    endproperty
    a_tout_en: assert property (p_tout_en) else $error("timeout enable");
    property p_tout_rst;
        !tout_written_reg |-> timeout_reg == 16'hffff;
    endproperty
    a_tout_rst: assert property (p_tout_rst) else $error("timeout reset value");
    property p_tx_null;
        s_tx_silent |=> pcm_transmit_output[15:0] == 16'h0000 && tx_nulled[0];
    endproperty
    a_tx_null: assert property (p_tx_null) else $error("tx not null");
    property p_mask_gain;
        wr_fire && id_reg == `CCC_ID_RX_GAIN && channel_command_mask[2]
            |=> rx_gain_reg[2] == $past(wr_word);
    endproperty
    a_mask_gain: assert property (p_mask_gain) else $error("masked gain write");
    property p_nomask;
        wr_fire && id_reg == `CCC_ID_TIMEOUT |=> timeout_reg == $past(wr_word);
    endproperty
    a_nomask: assert property (p_nomask) else $error("timeout not stored");
    property p_coef;
        wr_fire && id_reg == `CCC_ID_FILT_B && channel_command_mask[1]
            |=> coef_mem[1][$past(wr_addr)] == $past(wr_word);
    endproperty
    a_coef: assert property (p_coef) else $error("coefficient not stored");
    property p_read;
        s_tout_read |=> tx_word_reg == $past(timeout_reg) ##[1:3] co_oe;
    endproperty
    a_read: assert property (p_read) else $error("read not loaded");
endmodule
`default_nettype wire

/* File: verification/ccc_mcu_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Controller driving the serial control port
module ccc_mcu_model
(
    output logic cs_n,
    output logic cclk,
    output logic ci,
    input wire logic co_out,
    input wire logic co_oe
);
    logic [7:0] tx_q[$];
    logic [7:0] rx_q[$];
    // Deselected, shift clock parked high
    initial
    begin
        cs_n = 1'b1;
        cclk = 1'b1;
        ci = 1'b0;
    end
    // Command byte then payload, MSB first; reply sampled before each fall
    task automatic run_frame();
        logic [7:0] b;
        logic [7:0] r;
        rx_q = {};
        cs_n = 1'b0;
        #200;
        foreach (tx_q[i])
        begin
            b = tx_q[i];
            for (int k = 7; k >= 0; k--)
            begin
                ci = b[k];
                #150;
                r[k] = co_oe ? co_out : 1'b1; // Pull-up holds a released line high
                #10;
                cclk = 1'b0;
                #160;
                cclk = 1'b1;
            end
            rx_q.push_back(r);
        end
        // Keeps every pin change off the core's rising edge
        #120;
        cs_n = 1'b1;
        // Released line flips so a stale bit is never mistaken for data
        ci = ~ci;
        #600;
    endtask
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ccc_pkg::*;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic cs_n, cclk, ci, co_out, co_oe, meter, t_en;
    logic [3:0] mask = 4'h0;
    logic [63:0] rx_s = '0;
    logic [63:0] tx_s = '0;
    logic [63:0] rx_o, tx_o;
    logic [3:0] lm_en, lm_900, rx_m, tx_n;
    logic [31:0] t_len;
    logic [31:0] seed = 32'h3354;
    logic [15:0] lm_w = 16'haa00;
    logic [15:0] to_w = 16'hffff;
    logic [15:0] rxg[4] = '{default: 16'h0000};
    logic [15:0] txg[4] = '{default: 16'h0000};
    logic [15:0] wbuf[26];
    logic [15:0] ebuf[26];
    int mismatches = 0;
    int total_checks = 0;

    // ==========================================
    // Clock, design and controller
    always #20 core_clk = ~core_clk;

    ccc_cmd_core dut (.core_clk(core_clk), .nrst(nrst), .cs_n(cs_n), .cclk(cclk), .ci(ci),
        .co_out(co_out), .co_oe(co_oe), .channel_command_mask(mask), .rx_sample(rx_s),
        .tx_sample(tx_s), .receive_analog_output(rx_o), .pcm_transmit_output(tx_o),
        .line_match_en(lm_en), .line_match_900(lm_900), .metering_pulse_flag(meter),
        .timeout_enable_bit(t_en), .timeout_len_ps(t_len), .rx_muted(rx_m), .tx_nulled(tx_n));

    ccc_mcu_model mcu (.cs_n(cs_n), .cclk(cclk), .ci(ci), .co_out(co_out), .co_oe(co_oe));

    // ==========================================
    // Helpers
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Q15 product, truncated; zero gain forces silence
    function automatic logic [15:0] scl(input logic [15:0] s, input logic [15:0] g);
        logic signed [31:0] p;
        p = $signed(s) * $signed(g);
        return (g == 16'h0000) ? 16'h0000 : p[30:15];
    endfunction

    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Words go low byte first
    task automatic frame(input logic [7:0] cmd, input int n);
        mcu.tx_q = {cmd};
        for (int i = 0; i < n; i++)
        begin
            mcu.tx_q.push_back(wbuf[i][7:0]);
            mcu.tx_q.push_back(wbuf[i][15:8]);
        end
        mcu.run_frame();
    endtask

    task automatic rd_cmp(input logic [6:0] id, input int n, input string what);
        frame({1'b1, id}, n);
        for (int i = 0; i < n; i++)
            chk({48'h0, mcu.rx_q[2*i+2], mcu.rx_q[2*i+1]}, {48'h0, ebuf[i]}, what);
    endtask

    // Fresh samples, then every decoded output against the model
    task automatic check_out();
        logic [63:0] er, et;
        logic [3:0] ee, e9, em, en;
        @(negedge core_clk);
        rx_s = {xs(), xs()};
        tx_s = {xs(), xs()};
        repeat (3) @(negedge core_clk);
        for (int c = 0; c < 4; c++)
        begin
            ee[c] = lm_w[2*c+1] ^ lm_w[2*c];
            e9[c] = lm_w[2*c] & ~lm_w[2*c+1];
            em[c] = rxg[c] == 16'h0000;
            en[c] = txg[c] == 16'h0000;
            er[16*c +: 16] = scl(rx_s[16*c +: 16], rxg[c]);
            et[16*c +: 16] = scl(tx_s[16*c +: 16], txg[c]);
        end
        chk({56'h0, lm_en, lm_900}, {56'h0, ee, e9}, "line match");
        chk({63'h0, meter}, {63'h0, lm_w[8]}, "metering");
        chk({31'h0, t_en, t_len}, {31'h0, to_w[0], to_w[15:1] * 32'd62500 + 32'd31240},
            "timeout");
        chk({56'h0, rx_m, tx_n}, {56'h0, em, en}, "mute flags");
        chk(rx_o, er, "receive path");
        chk(tx_o, et, "transmit path");
    endtask

    // ==========================================
    // Main sequence
    initial
    begin
        repeat (3) @(negedge core_clk);
        nrst = 1'b1;
        repeat (8) @(negedge core_clk);
        check_out();
        ebuf[0] = 16'hffff;
        rd_cmp(7'h32, 1, "timeout readback");
        $display("test reset done");
        // Mask left clear: these two words must land anyway
        for (int t = 0; t < 4; t++)
        begin
            wbuf[0] = (t == 0) ? 16'h01e4 : xs();
            lm_w = wbuf[0];
            frame(8'h31, 1);
            wbuf[0] = (t == 0) ? 16'h0001 : (t == 1) ? 16'hfffe : xs();
            to_w = wbuf[0];
            frame(8'h32, 1);
            check_out();
            ebuf[0] = lm_w;
            rd_cmp(7'h31, 1, "line match readback");
        end
        $display("test setup words done");
        for (int t = 0; t < 8; t++)
        begin
            @(negedge core_clk);
            mask = (t >= 6) ? 4'h6 : 4'(xs());
            wbuf[0] = (t >= 6) ? 16'h0000 : xs();
            for (int c = 0; c < 4; c++)
                if (mask[c])
                    if (t[0])
                        txg[c] = wbuf[0];
                    else
                        rxg[c] = wbuf[0];
            frame(t[0] ? 8'h41 : 8'h40, 1);
            check_out();
            // Lowest masked channel answers, channel 0 when the mask is clear
            ebuf[0] = t[0] ? txg[0] : rxg[0];
            for (int c = 3; c >= 0; c--)
                if (mask[c])
                    ebuf[0] = t[0] ? txg[c] : rxg[c];
            rd_cmp(t[0] ? 7'h41 : 7'h40, 1, "gain readback");
        end
        $display("test gains done");
        for (int f = 0; f < 4; f++)
        begin
            int n;
            n = (f < 2) ? 17 : (f == 2) ? 26 : 5;
            @(negedge core_clk);
            mask = 4'ha;
            for (int i = 0; i < 26; i++)
                wbuf[i] = xs();
            frame({1'b0, 7'h42 + 7'(f)}, n);
            for (int m = 0; m < 3; m++)
            begin
                @(negedge core_clk);
                mask = (m == 0) ? 4'h1 : (m == 1) ? 4'h2 : 4'h8;
                for (int i = 0; i < n; i++)
                    ebuf[i] = (m == 0) ? 16'h0000 : wbuf[i];
                rd_cmp(7'h42 + 7'(f), n, "coefficients");
            end
        end
        $display("test coefficients done");
        wbuf[0] = 16'h0000;
        frame(8'h33, 1);
        ebuf[0] = to_w;
        rd_cmp(7'h32, 1, "timeout after unknown id");
        $display("test unknown id done");
        summarize();
    end

    // Hang guard
    initial
    begin
        repeat (90000) @(posedge core_clk);
        mismatches++;
        $display("CHECK FAILED at %0t: run did not finish", $time);
        summarize();
    end
endmodule
`default_nettype wire
